/* File: rcf_ring_fetch.sv */
// Operation
// - ring has start, length, head and tail settings with control fields
// - fetching only happens while the valid bit is set; a fetch already started still runs to completion after valid clears
// - toggling valid changes no other ring field, head kept
// - start address is a 4KB aligned linear base
// - length counts whole 4KB pages, at most 2MB
// - head is dword offset of next command, advanced on parse
// - data may be fetched ahead of downstream completion
// - ring is empty and idle when head equals tail
// - wrap count increments each time head wraps to start
// - wrap count shares the reported dword with head offset
// - smaller tail write means commands wrapped past buffer end
// - tail register holds an ownership semaphore flag
// - auto report on 64KB or 128KB head boundary crossing
// - report stores full head pointer at ring slot in status page
// - command type decoded and routed per parser mode
// - mutex disabled: flag reads zero, writes ignored
// - mutex enabled: read sets flag, tail write clears it
module rcf_ring_fetch (
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// ring programming
	input wire logic startWrite,
	input wire logic [rcf_pkg::ADDR_W-1:0] startAddrIn,
	input wire logic lengthWrite,
	input wire logic [rcf_pkg::LEN_W-1:0] lengthPagesIn,
	input wire logic headWrite,
	input wire logic [rcf_pkg::HEAD_W-1:0] headOffsetIn,
	input wire logic [rcf_pkg::WRAP_W-1:0] headWrapIn,
	input wire logic tailWrite,
	input wire logic [rcf_pkg::HEAD_W-1:0] tailOffsetIn,
	input wire logic tailRead,
	input wire logic validWrite,
	input wire logic validIn,
	input wire logic autoReportEnable,
	input wire logic reportSelect128k,
	// parser mode and status page
	input wire logic ringMutexEnable,
	input wire logic [2:0] engineDisable,
	input wire logic [rcf_pkg::ADDR_W-1:0] statusPageBase,
	input wire logic [rcf_pkg::ADDR_W-1:0] ringSlotOffset,
	// ring state readback
	output logic [rcf_pkg::ADDR_W-1:0] startAddr,
	output logic [rcf_pkg::LEN_W-1:0] lengthPages,
	output logic [rcf_pkg::HEAD_W-1:0] headOffset,
	output logic [rcf_pkg::WRAP_W-1:0] headWrap,
	output logic [rcf_pkg::HEAD_W-1:0] tailOffset,
	output logic inUse,
	output logic ringValid,
	output logic ringEmpty,
	output logic [rcf_pkg::DATA_W-1:0] headPointer,
	// memory port
	output logic memReq,
	output logic memWrite,
	output logic [rcf_pkg::ADDR_W-1:0] memAddr,
	output logic [rcf_pkg::DATA_W-1:0] memWdata,
	input wire logic memGrant,
	input wire logic memRvalid,
	input wire logic [rcf_pkg::DATA_W-1:0] memRdata,
	// command output toward engines
	output logic cmdValid,
	output logic [rcf_pkg::DATA_W-1:0] cmdData,
	output logic [3:0] cmdDest,
	input wire logic cmdReady
);
	rcf_pkg::rcf_state_e state;
	logic [rcf_pkg::HEAD_W-1:0] fetchOffset;
	// ring geometry and pointer steps
	logic [rcf_pkg::HEAD_W-1:0] ringLast;
	logic [rcf_pkg::LEN_W-1:0] lastPage;
	logic fetchWraps;
	logic [rcf_pkg::HEAD_W-1:0] fetchStep;
	logic [rcf_pkg::HEAD_W-1:0] headStep;
	logic crossed64k;
	logic crossed128k;
	// address pieces
	logic [rcf_pkg::ADDR_W-1:0] fetchByteOffset;
	logic [rcf_pkg::ADDR_W-1:0] fetchAddr;
	logic [rcf_pkg::ADDR_W-1:0] reportAddr;
	logic [rcf_pkg::HEAD_W-1:0] nextHead;
	logic headWraps;
	logic crossed;
	logic reportPending;
	logic [rcf_pkg::DATA_W-1:0] reportWord;
	logic [2:0] cmdType;
	logic [3:0] dest;
	logic [rcf_pkg::HEAD_W-1:0] nextFetch;

	// last dword index; zero pages rolls over to the 2MB size
	always_comb begin
		lastPage = lengthPages - 9'h001;
		ringLast = {lastPage, {rcf_pkg::PAGE_DW_SHIFT{1'b1}}};
	end
	assign ringEmpty = (headOffset == tailOffset);

	// head step, back to zero past the last dword
	always_comb begin
		headStep = headOffset + 19'h00001;
		headWraps = (headOffset >= ringLast);
		nextHead = headWraps ? '0 : headStep;
	end

	// fetch pointer runs the same ring, wrapping past the end
	always_comb begin
		fetchStep = fetchOffset + 19'h00001;
		fetchWraps = (fetchOffset >= ringLast);
		nextFetch = fetchWraps ? '0 : fetchStep;
	end

	// boundary crossing; a wrap always counts as one
	always_comb begin
		// pick the boundary bit by select
		crossed64k = (nextHead[rcf_pkg::RPT_BIT_64K] != headOffset[rcf_pkg::RPT_BIT_64K]);
		crossed128k = (nextHead[rcf_pkg::RPT_BIT_128K] != headOffset[rcf_pkg::RPT_BIT_128K]);
		if (headWraps) begin
			crossed = 1'b1;
		end else if (reportSelect128k) begin
			crossed = crossed128k;
		end else begin
			crossed = crossed64k;
		end
	end

	assign headPointer = {headWrap, 2'h0, headOffset};
	assign reportWord = headPointer;

	// start address and length, untouched by valid
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			startAddr <= '0;
			lengthPages <= '0;
		end else begin
			if (startWrite) begin
				startAddr <= {startAddrIn[rcf_pkg::ADDR_W-1:rcf_pkg::PAGE_SHIFT],
					12'h000};
			end
			if (lengthWrite) begin
				lengthPages <= lengthPagesIn;
			end
		end
	end

	// valid bit alone; other fields kept
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			ringValid <= 1'b0;
		end else if (validWrite) begin
			ringValid <= validIn;
		end
	end

	// tail and ownership flag
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			tailOffset <= '0;
			inUse <= 1'b0;
		end else begin
			if (tailWrite) begin
				tailOffset <= {tailOffsetIn[rcf_pkg::HEAD_W-1:1], 1'b0};
			end
			if (!ringMutexEnable) begin
				inUse <= 1'b0;
			end else if (tailWrite) begin
				inUse <= 1'b0;
			end else if (tailRead) begin
				inUse <= 1'b1;
			end
		end
	end

	// head offset and wrap count
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			headOffset <= '0;
			headWrap <= '0;
		end else if (headWrite) begin
			headOffset <= headOffsetIn;
			headWrap <= headWrapIn;
		end else if (cmdValid && cmdReady) begin
			headOffset <= nextHead;
			if (headWraps) begin
				headWrap <= headWrap + 11'h001;
			end
		end
	end

	// report request on boundary crossing
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			reportPending <= 1'b0;
		end else if (cmdValid && cmdReady && autoReportEnable && crossed) begin
			reportPending <= 1'b1;
		end else if (state == rcf_pkg::RCF_REPORT && memGrant) begin
			reportPending <= 1'b0;
		end
	end

	// destination decode
	always_comb begin
		cmdType = memRdata[rcf_pkg::CMD_TYPE_LSB +: 3];
		dest = 4'h1;
		case (cmdType)
			rcf_pkg::CMD_TYPE_MI: dest = 4'h1;
			rcf_pkg::CMD_TYPE_2D: dest = engineDisable[0] ? 4'h0 : 4'h2;
			rcf_pkg::CMD_TYPE_3D: dest = engineDisable[1] ? 4'h0 : 4'h4;
			default: dest = engineDisable[2] ? 4'h0 : 4'h8;
		endcase
	end

	// fetch machine; one dword in flight, may run ahead of engines
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state <= rcf_pkg::RCF_IDLE;
			fetchOffset <= '0;
			cmdValid <= 1'b0;
			cmdData <= '0;
			cmdDest <= '0;
		end else begin
			if (cmdValid && cmdReady) begin
				cmdValid <= 1'b0;
			end
			case (state)
				rcf_pkg::RCF_IDLE: begin
					if (headWrite) begin
						fetchOffset <= headOffsetIn;
					end else if (!cmdValid) begin
						fetchOffset <= headOffset;
					end
					if (reportPending) begin
						state <= rcf_pkg::RCF_REPORT;
					end else if (ringValid && !ringEmpty && !cmdValid && !headWrite) begin
						state <= rcf_pkg::RCF_FETCH;
					end
				end
				rcf_pkg::RCF_FETCH: begin
					if (memGrant) begin
						state <= rcf_pkg::RCF_WAIT;
					end
				end
				rcf_pkg::RCF_WAIT: begin
					if (memRvalid) begin
						cmdValid <= 1'b1;
						cmdData <= memRdata;
						cmdDest <= dest;
						fetchOffset <= nextFetch;
						state <= rcf_pkg::RCF_IDLE;
					end
				end
				rcf_pkg::RCF_REPORT: begin
					if (memGrant) begin
						state <= rcf_pkg::RCF_IDLE;
					end
				end
				default: state <= rcf_pkg::RCF_IDLE;
			endcase
		end
	end

	// byte addresses for a fetch and for the report slot
	always_comb begin
		fetchByteOffset = {{(rcf_pkg::ADDR_W-rcf_pkg::HEAD_W-rcf_pkg::DW_SHIFT){1'b0}},
			fetchOffset, 2'h0};
		fetchAddr = startAddr + fetchByteOffset;
		// report slot dword index scaled to bytes
		reportAddr = statusPageBase + (ringSlotOffset << rcf_pkg::DW_SHIFT);
	end

	// memory request drive
	always_comb begin
		memReq = 1'b0;
		memWrite = 1'b0;
		memWdata = '0;
		memAddr = fetchAddr;
		case (state)
			rcf_pkg::RCF_FETCH: begin
				memReq = 1'b1;
				memAddr = fetchAddr;
			end
			rcf_pkg::RCF_REPORT: begin
				memReq = 1'b1;
				memWrite = 1'b1;
				memWdata = reportWord;
				memAddr = reportAddr;
			end
			default: begin
				memReq = 1'b0;
			end
		endcase
	end
endmodule

/* File: rcf_pkg.sv */
package rcf_pkg;
	localparam int ADDR_W = 32;
	localparam int DATA_W = 32;
	// ring size in dwords: up to 2MB / 4 bytes
	localparam int HEAD_W = 19;
	localparam int LEN_W = 9;
	localparam int WRAP_W = 11;
	localparam int PAGE_SHIFT = 12;
	localparam int PAGE_DW_SHIFT = 10;
	localparam int DW_SHIFT = 2;
	localparam logic [LEN_W-1:0] LEN_MAX_PAGES = 9'h1FF;
	// 64KB and 128KB report boundaries in dword offset bits
	localparam int RPT_BIT_64K = 14;
	localparam int RPT_BIT_128K = 15;
	localparam logic [ADDR_W-1:0] RPT_SLOT_BYTES = 32'h00000004;
	// command type field position
	localparam int CMD_TYPE_LSB = 29;
	localparam logic [2:0] CMD_TYPE_MI = 3'h0;
	localparam logic [2:0] CMD_TYPE_2D = 3'h2;
	localparam logic [2:0] CMD_TYPE_3D = 3'h3;
	// head pointer register layout
	localparam int HP_WRAP_LSB = 21;
	localparam int HP_OFF_LSB = 2;
	typedef enum logic [3:0] {
		RCF_IDLE = 4'h1,
		RCF_FETCH = 4'h2,
		RCF_WAIT = 4'h4,
		RCF_REPORT = 4'h8
	} rcf_state_e;
endpackage

/* File: rcf_ring_fetch_props.sv */
module rcf_ring_fetch_props (
	// clock, reset and requests
	input wire logic clock, rst_n, headWrite, tailWrite, tailRead, validWrite,
	input wire logic ringMutexEnable, cmdValid, cmdReady, memReq, memWrite,
	// observed ring state
	input wire logic inUse, ringValid, ringEmpty,
	input wire logic [rcf_pkg::LEN_W-1:0] lengthPages,
	input wire logic [rcf_pkg::HEAD_W-1:0] headOffset, tailOffset,
	input wire logic [rcf_pkg::WRAP_W-1:0] headWrap,
	input wire logic [rcf_pkg::DATA_W-1:0] headPointer, memWdata, cmdData
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	logic [19:0] lenDw;
	logic wrapNow;
	logic take;
	assign lenDw = (lengthPages == 9'h0) ? 20'h80000 : {1'b0, lengthPages, 10'h000};
	assign wrapNow = ({1'b0, headOffset} + 20'h00001) == lenDw;
	assign take = cmdValid && cmdReady && !headWrite;
	idle_no_fetch_a: assert property (memReq && !memWrite |-> ringValid && !ringEmpty)
		else $error("fetch from idle ring");
	empty_flag_a: assert property (ringEmpty == (headOffset == tailOffset))
		else $error("empty flag wrong");
	head_step_a: assert property (take |=> headOffset ==
		($past(wrapNow) ? 19'h00000 : $past(headOffset) + 19'h00001)) else $error("head step wrong");
	wrap_count_a: assert property (take && wrapNow |=> headWrap == $past(headWrap) + 11'h001)
		else $error("wrap count missed");
	head_hold_a: assert property (!take && !headWrite |=> $stable(headOffset))
		else $error("head moved");
	pointer_word_a: assert property (headPointer == {headWrap, 2'b00, headOffset})
		else $error("head pointer layout");
	report_data_a: assert property (memReq && memWrite |-> memWdata == headPointer)
		else $error("report data wrong");
	mutex_off_a: assert property (!ringMutexEnable ##1 !ringMutexEnable |-> !inUse)
		else $error("flag set with mutex off");
	read_sets_a: assert property (ringMutexEnable && tailRead && !tailWrite |=> inUse)
		else $error("read did not set flag");
	write_clears_a: assert property (tailWrite |=> !inUse)
		else $error("tail write kept flag");
	cmd_hold_a: assert property (cmdValid && !cmdReady |=> cmdValid && $stable(cmdData))
		else $error("command dropped");
endmodule
bind rcf_ring_fetch rcf_ring_fetch_props u_rcf_ring_fetch_props (.*);

/* File: rcf_mem_model.sv */
module rcf_mem_model (
	// memory port
	input wire logic clock, slow, memReq, memWrite,
	input wire logic [31:0] memAddr, memWdata,
	output logic memGrant, memRvalid,
	output logic [31:0] memRdata, wrAddr, wrData,
	output logic [7:0] wrCount
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] cnt = 3'h0;
	initial {memGrant, memRvalid, memRdata, wrAddr, wrData, wrCount} = '0;
	always @(posedge clock) begin
		memRvalid <= 1'b0;
		// no stale data between returns
		memRdata <= ~memRdata;
		if (memGrant) begin
			memGrant <= 1'b0;
			cnt <= 3'h0;
			if (memWrite) begin
				wrAddr <= memAddr;
				wrData <= memWdata;
				wrCount <= wrCount + 8'h01;
			end else begin
				memRvalid <= 1'b1;
				memRdata <= {memAddr[2] ? 3'h2 : 3'h0, 5'h00, memAddr[23:0]};
			end
		end else if (memReq) begin
			cnt <= cnt + 3'h1;
			memGrant <= !slow || cnt == 3'h3;
		end
	end
endmodule

/* File: rcf_ring_fetch_bench.sv */
module rcf_ring_fetch_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock, rst_n, startWrite, lengthWrite, headWrite, tailWrite, tailRead, validWrite;
	logic validIn, autoReportEnable, reportSelect128k, ringMutexEnable, slow, cmdReady;
	logic inUse, ringValid, ringEmpty, memReq, memWrite, memGrant, memRvalid, cmdValid;
	logic [2:0] engineDisable;
	logic [3:0] cmdDest;
	logic [7:0] wrCount;
	logic [8:0] lengthPagesIn, lengthPages;
	logic [10:0] headWrapIn, headWrap;
	logic [18:0] headOffsetIn, tailOffsetIn, headOffset, tailOffset;
	logic [19:0] expHead, lenDw;
	logic [31:0] startAddrIn, startAddr, statusPageBase, ringSlotOffset, headPointer, memAddr;
	logic [31:0] memWdata, memRdata, cmdData, wrAddr, wrData, expAddr;
	int miscompares = 0, checks_done = 0, cyc = 0, taken = 0;
	rcf_ring_fetch u_rcf_ring_fetch (.*);
	rcf_mem_model u_rcf_mem_model (.*);
	task automatic chk(input string what, input logic [31:0] exp, got);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic tick();
		@(posedge clock);
		#1;
	endtask
	task automatic stop_test();
		$display("checks %0d miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic prog(input logic [31:0] s, input logic [8:0] l, input logic [18:0] h, t);
		{startAddrIn, lengthPagesIn, headOffsetIn, tailOffsetIn} = {s, l, h, t};
		{startWrite, lengthWrite, headWrite, tailWrite} = 4'hF;
		tick();
		{startWrite, lengthWrite, headWrite, tailWrite} = 4'h0;
		lenDw = (l == 9'h0) ? 20'h80000 : {1'b0, l, 10'h000};
		expHead = {1'b0, h};
		chk("startAddr", {s[31:12], 12'h000}, startAddr);
		chk("lengthPages", {23'h0, l}, {23'h0, lengthPages});
	endtask
	task automatic pulse(input int which, input logic v);
		validIn = v;
		if (which == 0) validWrite = 1'b1;
		else if (which == 1) tailRead = 1'b1;
		else tailWrite = 1'b1;
		tick();
		{validWrite, tailRead, tailWrite} = 3'h0;
	endtask
	task automatic drain(input int n);
		for (int i = 0; i < 3000 && taken < n; i++) tick();
		chk("commands", n, taken);
	endtask
	initial begin
		clock = 0;
		forever #50 clock = ~clock;
	end
	always @(posedge clock) begin
		#1 cmdReady = !slow || cyc[1];
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			stop_test();
		end
	end
	// settled acceptance sampled away from the edge
	always @(negedge clock) if (rst_n && cmdValid && cmdReady) begin
		expAddr = {startAddr[31:12], 12'h000} + {11'h0, expHead, 2'b00};
		chk("cmdData", {expAddr[2] ? 3'h2 : 3'h0, 5'h00, expAddr[23:0]}, cmdData);
		chk("cmdDest", expAddr[2] ? (engineDisable[0] ? 0 : 2) : 1, {28'h0, cmdDest});
		taken++;
		expHead = (expHead + 20'h1 == lenDw) ? 20'h0 : expHead + 20'h1;
	end
	initial begin
		{rst_n, startWrite, lengthWrite, headWrite, tailWrite, tailRead, validWrite} = '0;
		{validIn, autoReportEnable, reportSelect128k, ringMutexEnable, slow, cmdReady} = '0;
		{engineDisable, startAddrIn, lengthPagesIn, headOffsetIn, tailOffsetIn, headWrapIn} = '0;
		{expHead, lenDw} = '0;
		statusPageBase = 32'h00040000;
		ringSlotOffset = 32'h00000008;
		repeat (6) @(posedge clock);
		#1 rst_n = 1'b1;
		chk("resetState", 0, {headOffset, ringValid, inUse, memReq, cmdValid});
		prog(32'h00123456, 9'h001, 19'h00000, 19'h00004);
		repeat (20) tick();
		chk("fetchWhileInvalid", 0, taken);
		pulse(0, 1'b1);
		chk("headAfterEnable", 0, {13'h0, headOffset});
		drain(4);
		chk("emptyHead", {1'b1, 19'h00004}, {ringEmpty, headOffset});
		$display("test fetch done");
		pulse(0, 1'b0);
		{engineDisable, slow} = 4'h3;
		prog(32'h00200000, 9'h001, 19'h003FC, 19'h00004);
		pulse(0, 1'b1);
		drain(12);
		chk("wrapState", {11'h001, 19'h00004}, {headWrap, headOffset});
		$display("test wrap done");
		pulse(1, 1'b1);
		chk("flagMutexOff", 0, inUse);
		ringMutexEnable = 1'b1;
		pulse(1, 1'b1);
		pulse(1, 1'b1);
		chk("flagHeld", 1, inUse);
		pulse(2, 1'b1);
		chk("flagCleared", 0, inUse);
		$display("test mutex done");
		pulse(0, 1'b0);
		{engineDisable, slow, autoReportEnable, headWrapIn} = {4'h0, 1'b1, 11'h003};
		prog(32'h00300000, 9'h020, 19'h03FFC, 19'h04004);
		pulse(0, 1'b1);
		drain(20);
		chk("reportCount", 1, {24'h0, wrCount});
		chk("reportAddr", 32'h00040020, wrAddr);
		chk("reportData", 32'h00604000, wrData);
		$display("test report done");
		stop_test();
	end
endmodule
